//--- hw/wplr_pkg.sv
// Purpose: shared constants and decode helpers for the word port latency router.
// Assumes: one clock, word-addressed 32-bit port, fixed per-slave read latency.
// Notes:   both ends import this package.
//
// Functional notes
// R1: every transfer moves one whole 32-bit word
// R2: address counts words, not bytes
// R3: slave stores write word in strobe cycle
// R4: initiator holds valid data with write strobe
// R5: basic slave returns read word next cycle
// R6: any request may follow any other back-to-back
// R7: each slave has its own constant latency
// R8: extended port adds read valid and error
// R9: extended port only between static side, router
// R10: router fans extended port into plain ports
// R11: extended latency depends on addressed slave
// R12: effective latency is slave plus routing delay
// R13: read valid high when returned data present
// R14: two returns same cycle flag collision error
// R15: initiator schedules reads to avoid return collisions
// R16: decode address, steer strobes, data, return
// R17: valid and error pulse one cycle each
package wplr_pkg;

  // ----------------------------------------------------------------------
  // port geometry
  // ----------------------------------------------------------------------
  localparam int unsigned WPLR_DATA_W      = 32;
  localparam int unsigned WPLR_ADDR_W      = 16;
  localparam int unsigned WPLR_WIN_AW      = 12;
  localparam int unsigned WPLR_NSLV        = 4;
  localparam int unsigned WPLR_SEL_W       = WPLR_ADDR_W - WPLR_WIN_AW;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned WPLR_ROUTE_DELAY = 1;
  localparam int unsigned WPLR_MAX_LAT     = 8;
  localparam int unsigned WPLR_MAX_EFF     = WPLR_MAX_LAT + WPLR_ROUTE_DELAY;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [WPLR_DATA_W-1:0] WPLR_RDATA_RST = 32'h0000_0000;
  localparam logic [WPLR_ADDR_W-1:0] WPLR_ADDR_RST  = 16'h0000;

  typedef logic [WPLR_ADDR_W-1:0] wplr_addr_t;
  typedef logic [WPLR_DATA_W-1:0] wplr_word_t;

  // slave index taken from the upper address bits
  function automatic logic [WPLR_SEL_W-1:0] wplr_slave_of(input wplr_addr_t addr);
    return addr[WPLR_ADDR_W-1:WPLR_WIN_AW];
  endfunction : wplr_slave_of

  // true when the upper bits name a slave that exists
  function automatic logic wplr_mapped(input wplr_addr_t addr, input int unsigned nslv);
    return (32'(wplr_slave_of(addr)) < nslv);
  endfunction : wplr_mapped

endpackage : wplr_pkg

//--- hw/wplr_mem_if.sv
// Purpose: extended memory port between initiator and router.
// Assumes: both ends share sys_clk; no tri-state.
// Notes:   one modport per end.
`timescale 1ns/100ps
interface wplr_mem_if;
  import wplr_pkg::*;

  wplr_addr_t addr;
  wplr_word_t wdata;
  logic       write_strobe;
  logic       read_strobe;
  wplr_word_t rdata;
  logic       read_word_valid;
  logic       collision_err;

  modport initiator
  (
    output addr,
    output wdata,
    output write_strobe,
    output read_strobe,
    input  rdata,
    input  read_word_valid,
    input  collision_err
  );

  modport router
  (
    input  addr,
    input  wdata,
    input  write_strobe,
    input  read_strobe,
    output rdata,
    output read_word_valid,
    output collision_err
  );

endinterface : wplr_mem_if

//--- hw/wplr_router.sv
// Purpose: device end; splits the extended port into plain per-slave ports.
// Assumes: each slave returns read data exactly its configured cycles after
//          its read strobe; slaves store writes in the strobe cycle.
// Notes:   return path is registered, adding WPLR_ROUTE_DELAY cycles.
`timescale 1ns/100ps
module wplr_router #(
  parameter int unsigned NSLV                     = wplr_pkg::WPLR_NSLV,
  parameter int unsigned SLAVE_RETURN_DELAY [NSLV] = '{1, 2, 3, 4}
)(
  input  wire logic                                              sys_clk,
  input  wire logic                                              rstn,
  wplr_mem_if.router                                             ext,
  output      logic [NSLV-1:0][wplr_pkg::WPLR_WIN_AW-1:0]        slv_addr,
  output      logic [NSLV-1:0][wplr_pkg::WPLR_DATA_W-1:0]        slv_wdata,
  output      logic [NSLV-1:0]                                   slv_write_strobe,
  output      logic [NSLV-1:0]                                   slv_read_strobe,
  input  wire logic [NSLV-1:0][wplr_pkg::WPLR_DATA_W-1:0]        slv_rdata
);
  import wplr_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (NSLV < 1 || NSLV > (1 << WPLR_SEL_W))
  begin : g_bad_nslv
    $error("slave count does not fit the address decode");
  end
  for (genvar c = 0; c < NSLV; c++)
  begin : g_chk
    if (SLAVE_RETURN_DELAY[c] < 1 || SLAVE_RETURN_DELAY[c] > WPLR_MAX_LAT) // see R5
    begin : g_bad_lat
      $error("slave return delay out of range");
    end
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  // pend[s][k]: slave s drives its return data k cycles from now
  typedef struct packed {
    logic [NSLV-1:0][WPLR_MAX_LAT-1:0] pend;
    wplr_word_t                        rdata;
    logic                              valid;
    logic                              err;
  } wplr_rt_s;

  wplr_rt_s st_q;
  wplr_rt_s st_d;

  logic [WPLR_SEL_W-1:0] sel;
  logic                  hit;

  assign sel = wplr_slave_of(ext.addr);                               // see R2
  assign hit = wplr_mapped(ext.addr, NSLV);

  // ----------------------------------------------------------------------
  // forward path: strobes and write data reach only the decoded slave
  // ----------------------------------------------------------------------
  // kept combinational so a write lands in its own strobe cycle
  for (genvar s = 0; s < NSLV; s++)
  begin : g_fwd
    logic mine;
    assign mine                = hit && (32'(sel) == s);              // see R16
    assign slv_addr[s]         = ext.addr[WPLR_WIN_AW-1:0];           // see R10
    assign slv_wdata[s]        = mine ? ext.wdata : '0;               // see R1
    assign slv_write_strobe[s] = mine && ext.write_strobe;            // see R3
    assign slv_read_strobe[s]  = mine && ext.read_strobe;             // see R6
  end

  // ----------------------------------------------------------------------
  // return path
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [NSLV-1:0] arrive;
    int unsigned     n_arr;
    st_d   = st_q;
    arrive = '0;
    n_arr  = 0;
    st_d.rdata = '0;
    for (int s = 0; s < NSLV; s++)
    begin
      arrive[s] = st_q.pend[s][0];
      st_d.pend[s] = st_q.pend[s] >> 1;
      // each slave has one fixed slot in its own schedule
      if (slv_read_strobe[s])
      begin
        st_d.pend[s][SLAVE_RETURN_DELAY[s]-1] = 1'b1;                 // see R7
      end
      if (arrive[s])
      begin
        st_d.rdata = st_d.rdata | slv_rdata[s];                       // see R16
        n_arr      = n_arr + 1;
      end
    end
    // registered return gives slave delay plus the routing delay
    st_d.valid = (n_arr != 0);                                        // see R13
    st_d.err   = (n_arr > 1);                                         // see R14
    if (n_arr == 0)
    begin
      st_d.rdata = st_q.rdata;                                        // see R11
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= '{pend: '0, rdata: WPLR_RDATA_RST, valid: 1'b0, err: 1'b0};
    end
    else
    begin
      st_q <= st_d;                                                   // see R12
    end
  end

  // valid and error are one-cycle pulses per return or collision
  assign ext.rdata           = st_q.rdata;                            // see R8
  assign ext.read_word_valid = st_q.valid;                            // see R17
  assign ext.collision_err   = st_q.err;                              // see R9

endmodule : wplr_router

//--- hw/wplr_initiator.sv
// Purpose: static-side end; drives the extended port from a command port.
// Assumes: same slave delays as the router it faces.
// Notes:   refuses a read whose return would collide with one in flight.
`timescale 1ns/100ps
module wplr_initiator #(
  parameter int unsigned NSLV                     = wplr_pkg::WPLR_NSLV,
  parameter int unsigned SLAVE_RETURN_DELAY [NSLV] = '{1, 2, 3, 4}
)(
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  wplr_mem_if.initiator             ext,
  input  wire logic                 cmd_valid,
  input  wire logic                 cmd_write,
  input  wire wplr_pkg::wplr_addr_t cmd_addr,
  input  wire wplr_pkg::wplr_word_t cmd_wdata,
  output      logic                 cmd_ready,
  output      logic                 resp_valid,
  output      wplr_pkg::wplr_word_t resp_data,
  output      logic                 collision_seen
);
  import wplr_pkg::*;

  localparam int unsigned RSV_W = WPLR_MAX_EFF + 2;

  if (NSLV < 1 || NSLV > (1 << WPLR_SEL_W))
  begin : g_bad_nslv
    $error("slave count does not fit the address decode");
  end

  for (genvar c = 0; c < NSLV; c++)
  begin : g_chk
    if (SLAVE_RETURN_DELAY[c] < 1 || SLAVE_RETURN_DELAY[c] > WPLR_MAX_LAT)
    begin : g_bad_lat
      $error("slave return delay out of range");
    end
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  // rsv[k]: a return is due at the port k cycles from now
  typedef struct packed {
    wplr_addr_t       addr;
    wplr_word_t       wdata;
    logic             we;
    logic             re;
    logic [RSV_W-1:0] rsv;
    logic             rvalid;
    wplr_word_t       rdata;
    logic             coll;
  } wplr_in_s;

  wplr_in_s st_q;
  wplr_in_s st_d;

  // effective delay seen at the port for a given address
  function automatic int unsigned eff_delay(input wplr_addr_t a);
    int unsigned r;
    r = 0;
    for (int s = 0; s < NSLV; s++)
    begin
      if (32'(wplr_slave_of(a)) == s)
      begin
        r = SLAVE_RETURN_DELAY[s] + WPLR_ROUTE_DELAY;                 // see R12
      end
    end
    return r;
  endfunction : eff_delay

  int unsigned      e_cmd;
  logic             slot_busy;
  logic [RSV_W-1:0] rsv_next;

  assign e_cmd     = eff_delay(cmd_addr);
  assign rsv_next  = st_q.rsv >> 1;
  // strobe goes out next cycle, so its return is e_cmd past that
  assign slot_busy = wplr_mapped(cmd_addr, NSLV) && rsv_next[e_cmd];  // see R15
  assign cmd_ready = cmd_write || !slot_busy;                         // see R6

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_d        = st_q;
    st_d.we     = 1'b0;
    st_d.re     = 1'b0;
    st_d.rsv    = rsv_next;
    st_d.rvalid = ext.read_word_valid;
    st_d.coll   = ext.collision_err;
    if (ext.read_word_valid)
    begin
      st_d.rdata = ext.rdata;
    end
    if (cmd_valid && cmd_ready)
    begin
      st_d.addr = cmd_addr;                                           // see R2
      if (cmd_write)
      begin
        st_d.we    = 1'b1;
        st_d.wdata = cmd_wdata;                                       // see R4
      end
      else
      begin
        st_d.re = 1'b1;
        if (wplr_mapped(cmd_addr, NSLV))
        begin
          st_d.rsv[e_cmd] = 1'b1;                                     // see R15
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= '{addr: WPLR_ADDR_RST, wdata: '0, we: 1'b0, re: 1'b0, rsv: '0,
                rvalid: 1'b0, rdata: WPLR_RDATA_RST, coll: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign ext.addr         = st_q.addr;
  assign ext.wdata        = st_q.wdata;                               // see R1
  assign ext.write_strobe = st_q.we;
  assign ext.read_strobe  = st_q.re;
  assign resp_valid       = st_q.rvalid;
  assign resp_data        = st_q.rdata;
  assign collision_seen   = st_q.coll;

endmodule : wplr_initiator

//--- test/wplr_mem_props.sv
// Purpose: timing checks on the extended port between initiator and router.
// Assumes: slave delays 1,2,3,4 plus one routing cycle; slave = addr[15:12].
// Notes:   watches interface signals only.
`timescale 1ns/100ps
module wplr_mem_props
(
  input wire logic                 sys_clk,
  input wire logic                 rstn,
  input wire wplr_pkg::wplr_addr_t addr,
  input wire wplr_pkg::wplr_word_t wdata,
  input wire logic                 write_strobe,
  input wire logic                 read_strobe,
  input wire wplr_pkg::wplr_word_t rdata,
  input wire logic                 read_word_valid,
  input wire logic                 collision_err
);
  import wplr_pkg::*;
  // ------------------------------------------------------------------
  // returns due this cycle, from strobes seen 2..5 cycles ago
  // ------------------------------------------------------------------
  logic [5:1]      rd_q;
  logic [5:1][3:0] sel_q;
  logic [2:0]      hits;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_q  <= '0;
      sel_q <= '0;
    end
    else
    begin
      rd_q  <= {rd_q[4:1], read_strobe};
      sel_q <= {sel_q[4:1], addr[15:12]};
    end
  end
  always_comb
  begin
    hits = '0;
    for (int s = 0; s < 4; s++)
      hits = hits + 3'(rd_q[s+2] && sel_q[s+2] == 4'(s));
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_valid_has_cause: assert property (read_word_valid |-> hits != 0)
    else $error("read valid without a due return");
  a_return_gives_valid: assert property (hits != 0 |-> read_word_valid)
    else $error("due return without read valid");
  a_clash_flags_err: assert property (hits > 1 |-> collision_err)
    else $error("clashing returns not flagged");
  a_err_has_cause: assert property (collision_err |-> hits > 1)
    else $error("error without a clash");
  a_err_with_valid: assert property (collision_err |-> read_word_valid)
    else $error("error without read valid");
  a_slave0_delay: assert property (read_strobe && addr[15:12] == 4'h0
    |-> ##2 read_word_valid)
    else $error("slave 0 return late");
  a_slave3_delay: assert property (read_strobe && addr[15:12] == 4'h3
    |-> ##5 read_word_valid)
    else $error("slave 3 return late");
  a_rdata_holds: assert property (!read_word_valid |-> $stable(rdata))
    else $error("read word moved without a return");
  a_one_request: assert property (!(read_strobe && write_strobe))
    else $error("two requests in one cycle");
  c_return: cover property (read_word_valid);
  c_wr_rd: cover property (write_strobe ##1 read_strobe);
  c_rd_rd: cover property (read_strobe ##1 read_strobe);
endmodule : wplr_mem_props

//--- test/tb_word_port_latency_router.sv
// Purpose: drives the initiator/router pair and a second router raw.
// Assumes: slave delays 1,2,3,4; slaves use four low address bits.
// Notes:   slave model hides stale words by showing their inverse.
`timescale 1ns/100ps
module wplr_tb_slave #(
  parameter int unsigned DELAY = 1
)(
  input  wire logic                 sys_clk,
  input  wire logic [11:0]          addr,
  input  wire wplr_pkg::wplr_word_t wdata,
  input  wire logic                 write_strobe,
  input  wire logic                 read_strobe,
  output      wplr_pkg::wplr_word_t rdata
);
  import wplr_pkg::*;
  wplr_word_t mem [16] = '{default: '0};
  wplr_word_t pipe_q [8] = '{default: '0};
  logic [7:0] vld_q = '0;
  always @(posedge sys_clk)
  begin
    if (write_strobe) mem[addr[3:0]] <= wdata;
    vld_q <= {vld_q[6:0], read_strobe};
    pipe_q[0] <= mem[addr[3:0]];
    for (int k = 1; k < 8; k++) pipe_q[k] <= pipe_q[k-1];
  end
  assign rdata = vld_q[DELAY-1] ? pipe_q[DELAY-1] : ~pipe_q[DELAY-1];
endmodule : wplr_tb_slave

module tb_word_port_latency_router;
  import wplr_pkg::*;
  localparam int unsigned DLY [4] = '{1, 2, 3, 4};
  typedef struct packed {int unsigned due; wplr_word_t data;} wplr_note_s;
  logic sys_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
  wplr_addr_t cmd_addr = '0;
  wplr_word_t cmd_wdata = '0, resp_data;
  logic cmd_ready, resp_valid, collision_seen;
  logic [3:0][11:0] a_ad, b_ad;
  logic [3:0][31:0] a_wd, b_wd, a_rd, b_rd;
  logic [3:0] a_we, a_re, b_we, b_re;
  int unsigned failures = 0, checks_done = 0, cyc = 0;
  logic [31:0] lfsr_q = 32'h0000_0021;
  wplr_word_t ref_mem [wplr_addr_t];
  wplr_note_s notes [$];
  wplr_mem_if ext_a();
  wplr_mem_if ext_b();
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  wplr_initiator u_wplr_initiator (.sys_clk, .rstn, .ext(ext_a), .cmd_valid, .cmd_write,
    .cmd_addr, .cmd_wdata, .cmd_ready, .resp_valid, .resp_data, .collision_seen);
  wplr_router u_wplr_router (.sys_clk, .rstn, .ext(ext_a), .slv_addr(a_ad), .slv_wdata(a_wd),
    .slv_write_strobe(a_we), .slv_read_strobe(a_re), .slv_rdata(a_rd));
  wplr_router u_wplr_router_b (.sys_clk, .rstn, .ext(ext_b), .slv_addr(b_ad), .slv_wdata(b_wd),
    .slv_write_strobe(b_we), .slv_read_strobe(b_re), .slv_rdata(b_rd));
  for (genvar s = 0; s < 4; s++)
  begin : g_slv
    wplr_tb_slave #(.DELAY(DLY[s])) u_a (.sys_clk, .addr(a_ad[s]), .wdata(a_wd[s]),
      .write_strobe(a_we[s]), .read_strobe(a_re[s]), .rdata(a_rd[s]));
    wplr_tb_slave #(.DELAY(DLY[s])) u_b (.sys_clk, .addr(b_ad[s]), .wdata(b_wd[s]),
      .write_strobe(b_we[s]), .read_strobe(b_re[s]), .rdata(b_rd[s]));
  end
  wplr_mem_props u_props (.sys_clk, .rstn, .addr(ext_a.addr), .wdata(ext_a.wdata),
    .write_strobe(ext_a.write_strobe), .read_strobe(ext_a.read_strobe), .rdata(ext_a.rdata),
    .read_word_valid(ext_a.read_word_valid), .collision_err(ext_a.collision_err));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  task automatic check(input wplr_word_t seen, input wplr_word_t exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s: saw %h, wanted %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // one command per call; a read to a mapped slave (a[15:12] < 4) leaves a note of when and what
  task automatic op(input logic wr, input wplr_addr_t a, output int unsigned waits);
    wplr_note_s n;
    int i;
    lfsr_q = lfsr_next(lfsr_q);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = lfsr_q;
    waits = 0;
    @(posedge sys_clk);
    while (!cmd_ready && waits < 20)
    begin
      waits++;
      @(posedge sys_clk);
    end
    check(32'(cmd_ready), 32'h1, "command never taken");
    if (wr)
      ref_mem[a] = lfsr_q;
    else if (a[15:12] < 4)
    begin
      n.due = cyc + DLY[a[15:12]] + 3;
      n.data = ref_mem.exists(a) ? ref_mem[a] : '0;
      i = 0;
      while (i < notes.size() && notes[i].due <= n.due) i++;
      notes.insert(i, n);
    end
    #1;
  endtask : op

  task automatic drive_b(input logic wr, input logic rd, input wplr_addr_t a, input wplr_word_t d);
    ext_b.write_strobe = wr;
    ext_b.read_strobe = rd;
    ext_b.addr = a;
    ext_b.wdata = d;
    @(posedge sys_clk);
    #1;
  endtask : drive_b

  always @(posedge sys_clk)
  begin
    wplr_note_s n;
    logic [3:0] hot;
    // an unmapped slave index shifts the bit out, so no slave may see it
    hot = 4'h1 << ext_a.addr[15:12];
    if (ext_a.write_strobe)
      check(32'(a_we), 32'(hot), "write fan-out");
    if (ext_a.read_strobe)
      check(32'(a_re), 32'(hot), "read fan-out");
    if (rstn)
      check(32'(collision_seen), 32'h0, "initiator saw clash");
    if (rstn && resp_valid !== 1'b0 && notes.size() == 0)
      check(32'h1, 32'h0, "unexpected return");
    else if (rstn && resp_valid !== 1'b0)
    begin
      n = notes.pop_front();
      check(32'(resp_valid), 32'h1, "return pulse");
      check(resp_data, n.data, "read word");
      check(32'(cyc), 32'(n.due), "read delay");
    end
  end

  initial
  begin
    #300us;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial
  begin
    int unsigned w;
    ext_b.write_strobe = 1'b0;
    ext_b.read_strobe = 1'b0;
    ext_b.addr = '0;
    ext_b.wdata = '0;
    repeat (12) @(posedge sys_clk);
    #1 rstn = 1'b1;
    @(posedge sys_clk);
    #1;
    for (int s = 0; s < 5; s++)
      for (int k = 0; k < 3; k++) op(1'b1, 16'(s * 4096 + k), w);
    // rising delay order never clashes, so no read may wait
    for (int s = 0; s < 4; s++)
      for (int k = 0; k < 3; k++)
      begin
        op(1'b0, 16'(s * 4096 + k), w);
        check(32'(w), 32'h0, "read stalled");
      end
    // second read would land on the first return: one cycle held off
    op(1'b0, 16'h3001, w);
    op(1'b0, 16'h2001, w);
    check(32'(w), 32'h1, "refusal count");
    repeat (40)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      op(lfsr_q[0], {2'b00, lfsr_q[5:4], 10'h000, lfsr_q[9:8]}, w);
    end
    op(1'b0, 16'h5000, w);
    op(1'b1, 16'h1002, w);
    op(1'b0, 16'h1002, w);
    cmd_valid = 1'b0;
    repeat (12) @(posedge sys_clk);
    check(32'(notes.size()), 32'h0, "returns missing");
    // raw port: slave 1 then slave 0 back to back return together
    drive_b(1'b1, 1'b0, 16'h0000, 32'h0000_00f0);
    drive_b(1'b1, 1'b0, 16'h1000, 32'h0000_0f00);
    drive_b(1'b0, 1'b1, 16'h1000, '0);
    drive_b(1'b0, 1'b1, 16'h0000, '0);
    drive_b(1'b0, 1'b0, 16'h0000, '0);
    check(32'(ext_b.collision_err), 32'h1, "clash error");
    check(32'(ext_b.read_word_valid), 32'h1, "clash valid");
    check(ext_b.rdata, 32'h0000_0ff0, "clash word");
    drive_b(1'b0, 1'b0, 16'h0000, '0);
    check(32'(ext_b.collision_err), 32'h0, "error pulse");
    tally_and_finish();
  end
endmodule : tb_word_port_latency_router
